// ---- logic/type1_consts.svh ----
// offsets, field codes and reset values of the type 1 message codec
`ifndef TYPE1_CONSTS_SVH
`define TYPE1_CONSTS_SVH
`define T1_MSG_BYTES 8
`define T1_IDX_RESERVED 0
`define T1_IDX_TYPE 1
`define T1_IDX_CODE 2
`define T1_IDX_OPCODE 3
`define T1_IDX_OPERAND 4
`define T1_IDX_STATUS_HI 4
`define T1_IDX_STATUS_LO 5
`define T1_MSG_TYPE 4'h1
`define T1_AXIS 4'h0
`define T1_ZERO_BYTE 8'h00
`define T1_OP_ACCEL 8'h1e
`define T1_OP_DECEL 8'h1f
`define T1_OP_VELOCITY 8'h1d
`define T1_RST_WORD 32'h0000_0000
`define T1_RST_STATUS 16'h0000
`endif

// ---- logic/type1_pkg.sv ----
// types shared by the type 1 message codec
package type1_pkg;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] code;
    logic [31:0] operand;
  } cmd_fields_s;
  typedef enum logic [1:0] {
    PARAM_NONE = 2'h0,
    PARAM_ACCEL = 2'h1,
    PARAM_DECEL = 2'h2,
    PARAM_VELOCITY = 2'h3
  } param_e;
  typedef enum logic [1:0] {
    ST_RECEIVE = 2'b00,
    ST_DECODE = 2'b01,
    ST_RESPOND = 2'b11
  } codec_state_e;
endpackage : type1_pkg

// ---- logic/cmd_field_decode.sv ----
// combinational field split of one received command payload
`include "type1_consts.svh"
module cmd_field_decode
  import type1_pkg::*;
#(
  parameter logic [7:0] REG_QUEUE_OP = 8'h01,
  parameter logic [7:0] REG_FETCH_OP = 8'h02,
  parameter logic [7:0] REG_WRITE_OP = 8'h03,
  parameter logic [7:0] REG_XFER_OP = 8'h04
) (
  input wire logic [63:0] msg,
  output logic type1_ok,
  output logic register_access,
  output param_e param_kind,
  output cmd_fields_s fields
);
  logic [7:0] type_byte;

  // byte i of the payload sits at msg[i*8 +: 8]
  function automatic logic [7:0] byte_at(input logic [63:0] m,
                                         input int idx);
    byte_at = m[idx*8 +: 8];
  endfunction : byte_at

  // the four register-access opcodes echo their register code
  function automatic logic is_register_cmd(input logic [7:0] op);
    is_register_cmd = (op == REG_QUEUE_OP) || (op == REG_FETCH_OP) ||
                      (op == REG_WRITE_OP) || (op == REG_XFER_OP);
  endfunction : is_register_cmd

  // field extraction; the operand is big endian, first byte highest
  always_comb begin
    type_byte = byte_at(msg, `T1_IDX_TYPE);
    type1_ok = (type_byte[3:0] == `T1_MSG_TYPE);
    fields.opcode = byte_at(msg, `T1_IDX_OPCODE);
    fields.code = byte_at(msg, `T1_IDX_CODE);
    fields.operand = {byte_at(msg, `T1_IDX_OPERAND),
                      byte_at(msg, `T1_IDX_OPERAND + 1),
                      byte_at(msg, `T1_IDX_OPERAND + 2),
                      byte_at(msg, `T1_IDX_OPERAND + 3)};
    register_access = is_register_cmd(fields.opcode);
    unique case (fields.opcode)
      `T1_OP_ACCEL: param_kind = PARAM_ACCEL;
      `T1_OP_DECEL: param_kind = PARAM_DECEL;
      `T1_OP_VELOCITY: param_kind = PARAM_VELOCITY;
      default: param_kind = PARAM_NONE;
    endcase
  end
endmodule : cmd_field_decode

// ---- logic/type1_command_message_codec.sv ----
// type 1 command decoder and response encoder of the drive
`include "type1_consts.svh"
module type1_command_message_codec
  import type1_pkg::*;
#(
  parameter logic [7:0] REG_QUEUE_OP = 8'h01,
  parameter logic [7:0] REG_FETCH_OP = 8'h02,
  parameter logic [7:0] REG_WRITE_OP = 8'h03,
  parameter logic [7:0] REG_XFER_OP = 8'h04
) (
  input wire logic clock,
  input wire logic resetn,
  // command byte stream from the transport
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready,
  // response byte stream to the transport
  output logic rsp_valid,
  output logic rsp_last,
  output logic [7:0] rsp_byte,
  input wire logic rsp_ready,
  // live status of the drive
  input wire logic [15:0] drive_status_word,
  // decoded command towards the motion logic
  output logic cmd_strobe,
  output logic cmd_register_access,
  output cmd_fields_s cmd_fields,
  output logic other_msg,
  output logic [31:0] set_accel_rate_cmd,
  output logic [31:0] set_decel_rate_cmd,
  output logic [31:0] set_velocity_cmd
);
  codec_state_e state_q, state_d;
  logic [7:0] rx_bytes_q [`T1_MSG_BYTES];
  logic [7:0] rx_bytes_d [`T1_MSG_BYTES];
  logic [2:0] rx_idx_q, rx_idx_d;
  logic [2:0] tx_idx_q, tx_idx_d;
  logic cmd_ready_q, cmd_ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_last_q, rsp_last_d;
  logic [7:0] rsp_byte_q, rsp_byte_d;
  logic [7:0] echo_op_q, echo_op_d;
  logic [7:0] echo_code_q, echo_code_d;
  logic [15:0] status_q, status_d;
  logic strobe_q, strobe_d;
  logic reg_access_q, reg_access_d;
  cmd_fields_s fields_q, fields_d;
  logic other_q, other_d;
  logic [31:0] accel_q, accel_d;
  logic [31:0] decel_q, decel_d;
  logic [31:0] vel_q, vel_d;
  logic [63:0] msg_flat;
  logic dec_type1_ok;
  logic dec_register_access;
  param_e dec_param;
  cmd_fields_s dec_fields;
  logic rx_take;
  logic tx_take;

  // flatten the received bytes so byte i lands at bit i*8
  for (genvar g = 0; g < `T1_MSG_BYTES; g++) begin : g_flat
    assign msg_flat[g*8 +: 8] = rx_bytes_q[g];
  end

  cmd_field_decode #(
    .REG_QUEUE_OP(REG_QUEUE_OP),
    .REG_FETCH_OP(REG_FETCH_OP),
    .REG_WRITE_OP(REG_WRITE_OP),
    .REG_XFER_OP(REG_XFER_OP)
  ) u_decode (
    .msg(msg_flat),
    .type1_ok(dec_type1_ok),
    .register_access(dec_register_access),
    .param_kind(dec_param),
    .fields(dec_fields)
  );

  // response payload byte for a given position
  function automatic logic [7:0] resp_byte_at(input logic [2:0] idx,
                                              input logic [7:0] op,
                                              input logic [7:0] code,
                                              input logic [15:0] st);
    unique case (idx)
      3'd0: resp_byte_at = `T1_ZERO_BYTE;
      3'd1: resp_byte_at = {`T1_AXIS, `T1_MSG_TYPE};
      3'd2: resp_byte_at = code;
      3'd3: resp_byte_at = op;
      3'd4: resp_byte_at = st[15:8];
      3'd5: resp_byte_at = st[7:0];
      3'd6, 3'd7: resp_byte_at = `T1_ZERO_BYTE;
    endcase
  endfunction : resp_byte_at

  assign rx_take = cmd_valid && cmd_ready_q;
  assign tx_take = rsp_valid_q && rsp_ready;

  // next-state logic: receive eight bytes, decode once, send eight bytes
  always_comb begin
    state_d = state_q;
    rx_bytes_d = rx_bytes_q;
    rx_idx_d = rx_idx_q;
    tx_idx_d = tx_idx_q;
    cmd_ready_d = cmd_ready_q;
    rsp_valid_d = rsp_valid_q;
    rsp_last_d = rsp_last_q;
    rsp_byte_d = rsp_byte_q;
    echo_op_d = echo_op_q;
    echo_code_d = echo_code_q;
    status_d = status_q;
    strobe_d = 1'b0;
    reg_access_d = reg_access_q;
    fields_d = fields_q;
    other_d = 1'b0;
    accel_d = accel_q;
    decel_d = decel_q;
    vel_d = vel_q;
    unique case (state_q)
      ST_RECEIVE: begin
        // ready rises one cycle after reset so no byte meets a half reset
        cmd_ready_d = 1'b1;
        if (rx_take) begin
          // a first marker restarts the payload, so a torn frame resyncs
          if (cmd_first) begin
            rx_bytes_d[0] = cmd_byte;
            rx_idx_d = 3'd1;
          end else begin
            rx_bytes_d[rx_idx_q] = cmd_byte;
            rx_idx_d = rx_idx_q + 3'd1;
            if (rx_idx_q == 3'd7) begin
              state_d = ST_DECODE;
              cmd_ready_d = 1'b0;
            end
          end
        end
      end
      ST_DECODE: begin
        rx_idx_d = 3'd0;
        if (dec_type1_ok) begin
          strobe_d = 1'b1;
          fields_d = dec_fields;
          reg_access_d = dec_register_access;
          echo_op_d = dec_fields.opcode;
          echo_code_d = dec_register_access ? dec_fields.code
                                            : `T1_ZERO_BYTE;
          status_d = drive_status_word;
          unique case (dec_param)
            PARAM_ACCEL: accel_d = dec_fields.operand;
            PARAM_DECEL: decel_d = dec_fields.operand;
            PARAM_VELOCITY: vel_d = dec_fields.operand;
            PARAM_NONE: accel_d = accel_q;
          endcase
          // every accepted command is answered
          state_d = ST_RESPOND;
          tx_idx_d = 3'd0;
          rsp_valid_d = 1'b1;
          rsp_last_d = 1'b0;
          rsp_byte_d = `T1_ZERO_BYTE;
        end else begin
          // not a type 1 payload: flag it and listen again
          other_d = 1'b1;
          state_d = ST_RECEIVE;
          cmd_ready_d = 1'b1;
        end
      end
      ST_RESPOND: begin
        if (tx_take) begin
          if (rsp_last_q) begin
            rsp_valid_d = 1'b0;
            rsp_last_d = 1'b0;
            rsp_byte_d = `T1_ZERO_BYTE;
            state_d = ST_RECEIVE;
            cmd_ready_d = 1'b1;
          end else begin
            tx_idx_d = tx_idx_q + 3'd1;
            rsp_byte_d = resp_byte_at(tx_idx_q + 3'd1, echo_op_q,
                                      echo_code_q, status_q);
            rsp_last_d = (tx_idx_q == 3'd6);
          end
        end
      end
      default: begin
        // illegal code: return to a clean receive
        state_d = ST_RECEIVE;
        cmd_ready_d = 1'b1;
        rsp_valid_d = 1'b0;
        rsp_last_d = 1'b0;
        rx_idx_d = 3'd0;
      end
    endcase
  end

  // state registers; payload bytes need no reset since they are
  // overwritten before they are ever decoded
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_RECEIVE;
      rx_idx_q <= 3'd0;
      tx_idx_q <= 3'd0;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_last_q <= 1'b0;
      rsp_byte_q <= `T1_ZERO_BYTE;
      echo_op_q <= `T1_ZERO_BYTE;
      echo_code_q <= `T1_ZERO_BYTE;
      status_q <= `T1_RST_STATUS;
      strobe_q <= 1'b0;
      reg_access_q <= 1'b0;
      fields_q <= '0;
      other_q <= 1'b0;
      accel_q <= `T1_RST_WORD;
      decel_q <= `T1_RST_WORD;
      vel_q <= `T1_RST_WORD;
    end else begin
      state_q <= state_d;
      rx_idx_q <= rx_idx_d;
      tx_idx_q <= tx_idx_d;
      cmd_ready_q <= cmd_ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_last_q <= rsp_last_d;
      rsp_byte_q <= rsp_byte_d;
      echo_op_q <= echo_op_d;
      echo_code_q <= echo_code_d;
      status_q <= status_d;
      strobe_q <= strobe_d;
      reg_access_q <= reg_access_d;
      fields_q <= fields_d;
      other_q <= other_d;
      accel_q <= accel_d;
      decel_q <= decel_d;
      vel_q <= vel_d;
    end
  end

  // payload storage, written only while receiving
  always_ff @(posedge clock) begin
    rx_bytes_q <= rx_bytes_d;
  end

  assign cmd_ready = cmd_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_last = rsp_last_q;
  assign rsp_byte = rsp_byte_q;
  assign cmd_strobe = strobe_q;
  assign cmd_register_access = reg_access_q;
  assign cmd_fields = fields_q;
  assign other_msg = other_q;
  assign set_accel_rate_cmd = accel_q;
  assign set_decel_rate_cmd = decel_q;
  assign set_velocity_cmd = vel_q;
endmodule : type1_command_message_codec

// ---- tb/type1_codec_asserts.sv ----
// port checker of the type 1 message codec
module type1_codec_asserts
  import type1_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_ready,
  input wire logic cmd_ready,
  input wire logic [15:0] drive_status_word,
  input wire logic cmd_strobe,
  input wire logic cmd_register_access,
  input wire cmd_fields_s cmd_fields,
  input wire logic other_msg,
  input wire logic [31:0] set_accel_rate_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rx_q;
  logic [15:0] prev_q;
  logic [15:0] snap_q;
  // reply byte index; status as the decode cycle saw it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_q <= 3'h0;
      prev_q <= 16'h0000;
      snap_q <= 16'h0000;
    end else begin
      if (rsp_valid && rsp_ready) rx_q <= rx_q + 3'h1;
      prev_q <= drive_status_word;
      if (cmd_strobe) snap_q <= prev_q;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_type;
    rsp_valid && rx_q == 3'h1 |-> rsp_byte == 8'h01;
  endproperty
  property p_zero;
    rsp_valid && (rx_q == 3'h0 || rx_q >= 3'h6) |-> rsp_byte == 8'h00;
  endproperty
  property p_code;
    rsp_valid && rx_q == 3'h2 |->
      rsp_byte == (cmd_register_access ? cmd_fields.code : 8'h00);
  endproperty
  property p_opcode;
    rsp_valid && rx_q == 3'h3 |-> rsp_byte == cmd_fields.opcode;
  endproperty
  property p_status;
    rsp_valid && rx_q[2:1] == 2'b10 |->
      rsp_byte == (rx_q[0] ? snap_q[7:0] : snap_q[15:8]);
  endproperty
  property p_answer;
    cmd_strobe |-> rsp_valid && rx_q == 3'h0 && !cmd_ready;
  endproperty
  property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte);
  endproperty
  property p_last;
    rsp_valid && rsp_ready && rsp_last |-> rx_q == 3'h7 ##1
      !rsp_valid && cmd_ready;
  endproperty
  property p_other;
    other_msg |-> !cmd_strobe && !rsp_valid && cmd_ready;
  endproperty
  property p_accel;
    cmd_strobe && cmd_fields.opcode == 8'h1e |->
      set_accel_rate_cmd == cmd_fields.operand;
  endproperty
  a_type: assert property (p_type) else $error("reply type bad");
  a_zero: assert property (p_zero) else $error("reply zero bad");
  a_code: assert property (p_code) else $error("reply code bad");
  a_opcode: assert property (p_opcode) else $error("opcode bad");
  a_status: assert property (p_status) else $error("status bad");
  a_answer: assert property (p_answer) else $error("no reply");
  a_hold: assert property (p_hold) else $error("reply byte moved");
  a_last: assert property (p_last) else $error("reply end bad");
  a_other: assert property (p_other) else $error("other bad");
  a_accel: assert property (p_accel) else $error("accel bad");
  c_strobe: cover property (cmd_strobe);
  c_other: cover property (other_msg);
  c_stall: cover property (rsp_valid && !rsp_ready);
endmodule : type1_codec_asserts

// ---- tb/host_model.sv ----
// host side model: sends command payloads, takes replies
module host_model (
  input wire logic clock,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [7:0] rsp_byte,
  output logic cmd_valid,
  output logic cmd_first,
  output logic [7:0] cmd_byte,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_byte = 8'h00;
    rsp_ready = 1'b0;
  end
  // byte zero first, each held until the codec takes it
  task automatic send(input logic [63:0] m);
    for (int i = 0; i < 8; i++) begin
      cmd_valid <= 1'b1;
      cmd_first <= (i == 0);
      cmd_byte <= m[63 - 8 * i -: 8];
      do @(posedge clock); while (!cmd_ready);
    end
    cmd_valid <= 1'b0;
    cmd_first <= 1'b0;
    cmd_byte <= ~m[7:0]; // idle bus must not look like data
  endtask : send
  // a slow host drops ready every other cycle
  task automatic recv(input bit slow, output logic [63:0] r);
    r = 64'h0;
    rsp_ready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge clock);
      if (rsp_valid && rsp_ready) begin
        r = {r[55:0], rsp_byte};
        if (rsp_last) break;
      end
      rsp_ready <= slow ? ~rsp_ready : 1'b1;
    end
    rsp_ready <= 1'b0;
  endtask : recv
endmodule : host_model

// ---- tb/type1_command_message_codec_test.sv ----
// self-checking bench of the type 1 message codec
module type1_command_message_codec_test
  import type1_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, cmd_valid, cmd_first, cmd_ready, rsp_valid;
  logic rsp_last, rsp_ready, cmd_strobe, cmd_register_access, other_msg;
  logic [7:0] cmd_byte, rsp_byte;
  logic [15:0] drive_status_word;
  logic [31:0] set_accel_rate_cmd, set_decel_rate_cmd, set_velocity_cmd;
  cmd_fields_s cmd_fields;
  int n_errors, total_checks;
  type1_command_message_codec uut (.clock, .resetn, .cmd_valid,
    .cmd_first, .cmd_byte, .cmd_ready, .rsp_valid, .rsp_last, .rsp_byte,
    .rsp_ready, .drive_status_word, .cmd_strobe, .cmd_register_access,
    .cmd_fields, .other_msg, .set_accel_rate_cmd, .set_decel_rate_cmd,
    .set_velocity_cmd);
  host_model host (.clock, .cmd_ready, .rsp_valid, .rsp_last, .rsp_byte,
    .cmd_valid, .cmd_first, .cmd_byte, .rsp_ready);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [63:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // one command and its reply; the expected reply is built here
  task automatic run(input logic [7:0] op, code, input logic [31:0] v,
                     input bit reg_op, slow);
    logic [63:0] r;
    logic [63:0] e;
    host.send({16'h0001, code, op, v});
    // status is read after the send, once the bench's update has landed
    e = {16'h0001, reg_op ? code : 8'h00, op, drive_status_word, 16'h0};
    host.recv(slow, r);
    chk("reply", e, r);
    chk("reg flag", 64'(reg_op), 64'(cmd_register_access));
    chk("operand", 64'(v), 64'(cmd_fields.operand));
  endtask : run
  // rate commands, a negative operand among them
  task automatic t_rates();
    drive_status_word <= 16'ha55a;
    run(8'h1e, 8'h00, 32'h0000_0258, 1'b0, 1'b0);
    chk("accel", 64'h0258, 64'(set_accel_rate_cmd));
    run(8'h1f, 8'h00, 32'hffff_fda8, 1'b0, 1'b1);
    chk("decel", 64'hffff_fda8, 64'(set_decel_rate_cmd));
    run(8'h1d, 8'h00, 32'h0000_04b0, 1'b0, 1'b0);
    chk("velocity", 64'h04b0, 64'(set_velocity_cmd));
    chk("accel kept", 64'h0258, 64'(set_accel_rate_cmd));
    $display("rates done");
  endtask : t_rates
  // code echoed only for the four register opcodes
  task automatic t_register();
    logic [7:0] ops [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
    drive_status_word <= 16'h3cc3;
    foreach (ops[i]) run(ops[i], 8'h40 + 8'(i), 32'h1, 1'b1, i[0]);
    run(8'h8b, 8'h07, 32'h0000_4cb2, 1'b0, 1'b0);
    $display("register done");
  endtask : t_register
  // wrong type field: flagged, not decoded, not answered
  task automatic t_other();
    logic [3:0] hits;
    logic bad;
    hits = 4'h0;
    bad = 1'b0;
    host.send(64'h0002_001e_0000_7777);
    repeat (6) begin
      @(posedge clock);
      hits += 4'(other_msg);
      bad |= rsp_valid | cmd_strobe;
    end
    chk("other pulses", 64'h1, 64'(hits));
    chk("no decode", 64'h0, 64'(bad));
    chk("accel kept", 64'h0258, 64'(set_accel_rate_cmd));
    run(8'h66, 8'h00, 32'h0, 1'b0, 1'b0);
    $display("other done");
  endtask : t_other
  initial begin
    n_errors = 0;
    total_checks = 0;
    resetn = 1'b0;
    drive_status_word = 16'h0000;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    t_rates();
    t_register();
    t_other();
    give_verdict();
  end
  // cut a hang short well past the expected run
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
endmodule : type1_command_message_codec_test
bind type1_command_message_codec type1_codec_asserts chk_i (.clock,
  .resetn, .rsp_valid, .rsp_last, .rsp_byte, .rsp_ready, .cmd_ready,
  .drive_status_word, .cmd_strobe, .cmd_register_access, .cmd_fields,
  .other_msg, .set_accel_rate_cmd);
